// [inc/hle_defines.vh]
// Purpose: constants for the hub link error log
// Assumes: byte-wide hub registers and 32-bit global registers on a plain register port
// Notes: offsets are byte addresses of the configuration space
`ifndef HLE_DEFINES_VH
`define HLE_DEFINES_VH
`define HLE_ADDR_W 8
`define HLE_OFF_FIRST 8'h50
`define HLE_OFF_NEXT 8'h52
`define HLE_OFF_MASK 8'h54
`define HLE_OFF_GFIRST 8'h40
`define HLE_OFF_GNEXT 8'h44
`define HLE_RST_LOG 7'h00
`define HLE_RST_MASK 7'h00
`define HLE_MASK_WR 7'h7d
`define HLE_FATAL_SET 7'h2b
`define HLE_NONFATAL_SET 7'h54
`define HLE_GBIT_FATAL 25
`define HLE_GBIT_NONFATAL 11
`define HLE_BIT_TABORT 6
`define HLE_BIT_ECFG 5
`define HLE_BIT_DPAR 4
`define HLE_BIT_RANGE 3
`define HLE_BIT_IPAR 2
`define HLE_BIT_ILLEGAL 1
`define HLE_BIT_ACPAR 0
`endif

// [verilog/hle_sticky_bit.v]
// Purpose: one sticky write-one-to-clear flag
// Assumes: set has priority over a clear in the same cycle
// Notes: no reset input, the flag survives reset by intent
`timescale 1ns/1ns
module hle_sticky_bit (
  // clock
  input wire core_clk,
  // control
  input wire set_i,
  input wire clr_i,
  // state
  output reg q_r
);
  initial q_r = 1'b0;
  always @(posedge core_clk) begin
    if (set_i) begin
      q_r <= 1'b1;
    end else if (clr_i) begin
      q_r <= 1'b0;
    end
  end
endmodule // hle_sticky_bit

// [verilog/hle_error_log.v]
// Purpose: hub link error logging registers
// Assumes: error inputs are one-cycle pulses synchronous to core_clk
// Notes: log and mask bits are sticky; reset only clears the read data and the two summary outputs
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`include "hle_defines.vh"
module hle_error_log (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_r,
  // error sources, one-cycle pulses
  input wire err_target_abort,
  input wire err_ecfg_legacy,
  input wire err_data_parity,
  input wire err_addr_range,
  input wire err_internal_parity,
  input wire err_illegal_access,
  input wire err_addr_cmd_parity,
  // summary toward the global level
  output reg fatal_logged_r,
  output reg nonfatal_logged_r
);
  wire [6:0] err_raw;
  wire [6:0] err_live;
  wire [6:0] first_q;
  wire [6:0] next_q;
  wire [6:0] first_set;
  wire [6:0] next_set;
  wire [6:0] first_clr;
  wire [6:0] next_clr;
  wire any_first;
  wire fatal_ev;
  wire nonfatal_ev;
  wire gf_fatal_q;
  wire gf_nonf_q;
  wire gn_fatal_q;
  wire gn_nonf_q;
  wire wr_first;
  wire wr_next;
  wire wr_mask;
  wire wr_gfirst;
  wire wr_gnext;
  reg [6:0] hub_error_mask_r;
  reg [31:0] rd_nxt;

  assign err_raw[`HLE_BIT_TABORT] = err_target_abort;
  assign err_raw[`HLE_BIT_ECFG] = err_ecfg_legacy;
  assign err_raw[`HLE_BIT_DPAR] = err_data_parity;
  assign err_raw[`HLE_BIT_RANGE] = err_addr_range;
  assign err_raw[`HLE_BIT_IPAR] = err_internal_parity;
  assign err_raw[`HLE_BIT_ILLEGAL] = err_illegal_access;
  assign err_raw[`HLE_BIT_ACPAR] = err_addr_cmd_parity;

  // masking happens once, ahead of every log and summary
  assign err_live = err_raw & ~hub_error_mask_r;

  assign any_first = |first_q;
  // whole cycle's errors go to the first log while it is empty
  assign first_set = any_first ? 7'h00 : err_live;
  assign next_set = any_first ? err_live : 7'h00;

  assign wr_first = reg_wr && (reg_addr == `HLE_OFF_FIRST);
  assign wr_next = reg_wr && (reg_addr == `HLE_OFF_NEXT);
  assign wr_mask = reg_wr && (reg_addr == `HLE_OFF_MASK);
  assign wr_gfirst = reg_wr && (reg_addr == `HLE_OFF_GFIRST);
  assign wr_gnext = reg_wr && (reg_addr == `HLE_OFF_GNEXT);
  // bit 7 of the data never reaches a flag
  assign first_clr = wr_first ? reg_wdata[6:0] : 7'h00;
  assign next_clr = wr_next ? reg_wdata[6:0] : 7'h00;

  // class vectors keep the summary terms readable per source
  wire [6:0] fatal_live;
  wire [6:0] nonfatal_live;
  assign fatal_live = err_live & `HLE_FATAL_SET;
  assign nonfatal_live = err_live & `HLE_NONFATAL_SET;
  assign fatal_ev = |fatal_live;
  assign nonfatal_ev = |nonfatal_live;

  // target abort, bit 6
  hle_sticky_bit u_first_tabort (
    .core_clk(core_clk),
    .set_i(first_set[`HLE_BIT_TABORT]),
    .clr_i(first_clr[`HLE_BIT_TABORT]),
    .q_r(first_q[`HLE_BIT_TABORT])
  );
  hle_sticky_bit u_next_tabort (
    .core_clk(core_clk),
    .set_i(next_set[`HLE_BIT_TABORT]),
    .clr_i(next_clr[`HLE_BIT_TABORT]),
    .q_r(next_q[`HLE_BIT_TABORT])
  );

  // enhanced configuration access to the legacy link, bit 5
  hle_sticky_bit u_first_ecfg (
    .core_clk(core_clk),
    .set_i(first_set[`HLE_BIT_ECFG]),
    .clr_i(first_clr[`HLE_BIT_ECFG]),
    .q_r(first_q[`HLE_BIT_ECFG])
  );
  hle_sticky_bit u_next_ecfg (
    .core_clk(core_clk),
    .set_i(next_set[`HLE_BIT_ECFG]),
    .clr_i(next_clr[`HLE_BIT_ECFG]),
    .q_r(next_q[`HLE_BIT_ECFG])
  );

  // data phase parity, bit 4
  hle_sticky_bit u_first_dpar (
    .core_clk(core_clk),
    .set_i(first_set[`HLE_BIT_DPAR]),
    .clr_i(first_clr[`HLE_BIT_DPAR]),
    .q_r(first_q[`HLE_BIT_DPAR])
  );
  hle_sticky_bit u_next_dpar (
    .core_clk(core_clk),
    .set_i(next_set[`HLE_BIT_DPAR]),
    .clr_i(next_clr[`HLE_BIT_DPAR]),
    .q_r(next_q[`HLE_BIT_DPAR])
  );

  // out-of-range address, bit 3
  hle_sticky_bit u_first_range (
    .core_clk(core_clk),
    .set_i(first_set[`HLE_BIT_RANGE]),
    .clr_i(first_clr[`HLE_BIT_RANGE]),
    .q_r(first_q[`HLE_BIT_RANGE])
  );
  hle_sticky_bit u_next_range (
    .core_clk(core_clk),
    .set_i(next_set[`HLE_BIT_RANGE]),
    .clr_i(next_clr[`HLE_BIT_RANGE]),
    .q_r(next_q[`HLE_BIT_RANGE])
  );

  // bridge internal parity, bit 2
  hle_sticky_bit u_first_ipar (
    .core_clk(core_clk),
    .set_i(first_set[`HLE_BIT_IPAR]),
    .clr_i(first_clr[`HLE_BIT_IPAR]),
    .q_r(first_q[`HLE_BIT_IPAR])
  );
  hle_sticky_bit u_next_ipar (
    .core_clk(core_clk),
    .set_i(next_set[`HLE_BIT_IPAR]),
    .clr_i(next_clr[`HLE_BIT_IPAR]),
    .q_r(next_q[`HLE_BIT_IPAR])
  );

  // illegal access from the link, bit 1
  hle_sticky_bit u_first_illegal (
    .core_clk(core_clk),
    .set_i(first_set[`HLE_BIT_ILLEGAL]),
    .clr_i(first_clr[`HLE_BIT_ILLEGAL]),
    .q_r(first_q[`HLE_BIT_ILLEGAL])
  );
  hle_sticky_bit u_next_illegal (
    .core_clk(core_clk),
    .set_i(next_set[`HLE_BIT_ILLEGAL]),
    .clr_i(next_clr[`HLE_BIT_ILLEGAL]),
    .q_r(next_q[`HLE_BIT_ILLEGAL])
  );

  // address or command parity, bit 0
  hle_sticky_bit u_first_acpar (
    .core_clk(core_clk),
    .set_i(first_set[`HLE_BIT_ACPAR]),
    .clr_i(first_clr[`HLE_BIT_ACPAR]),
    .q_r(first_q[`HLE_BIT_ACPAR])
  );
  hle_sticky_bit u_next_acpar (
    .core_clk(core_clk),
    .set_i(next_set[`HLE_BIT_ACPAR]),
    .clr_i(next_clr[`HLE_BIT_ACPAR]),
    .q_r(next_q[`HLE_BIT_ACPAR])
  );

  // global summary: first log takes the event while both global bits are clear
  wire g_first_empty;
  assign g_first_empty = ~(gf_fatal_q | gf_nonf_q);
  // each global bit clears only on a write of 1 to its own position
  wire gf_fatal_set;
  wire gf_nonf_set;
  wire gn_fatal_set;
  wire gn_nonf_set;
  wire gf_fatal_clr;
  wire gf_nonf_clr;
  wire gn_fatal_clr;
  wire gn_nonf_clr;
  assign gf_fatal_set = fatal_ev && g_first_empty;
  assign gf_nonf_set = nonfatal_ev && g_first_empty;
  assign gn_fatal_set = fatal_ev && !g_first_empty;
  assign gn_nonf_set = nonfatal_ev && !g_first_empty;
  assign gf_fatal_clr = wr_gfirst && reg_wdata[`HLE_GBIT_FATAL];
  assign gf_nonf_clr = wr_gfirst && reg_wdata[`HLE_GBIT_NONFATAL];
  assign gn_fatal_clr = wr_gnext && reg_wdata[`HLE_GBIT_FATAL];
  assign gn_nonf_clr = wr_gnext && reg_wdata[`HLE_GBIT_NONFATAL];

  hle_sticky_bit u_gf_fatal (
    .core_clk(core_clk),
    .set_i(gf_fatal_set),
    .clr_i(gf_fatal_clr),
    .q_r(gf_fatal_q)
  );

  hle_sticky_bit u_gf_nonf (
    .core_clk(core_clk),
    .set_i(gf_nonf_set),
    .clr_i(gf_nonf_clr),
    .q_r(gf_nonf_q)
  );

  hle_sticky_bit u_gn_fatal (
    .core_clk(core_clk),
    .set_i(gn_fatal_set),
    .clr_i(gn_fatal_clr),
    .q_r(gn_fatal_q)
  );

  hle_sticky_bit u_gn_nonf (
    .core_clk(core_clk),
    .set_i(gn_nonf_set),
    .clr_i(gn_nonf_clr),
    .q_r(gn_nonf_q)
  );

  // bit 1 is read-only, so only the writable bits take new data
  wire [6:0] hub_error_mask_nxt;
  assign hub_error_mask_nxt = (reg_wdata[6:0] & `HLE_MASK_WR) |
                              (hub_error_mask_r & ~`HLE_MASK_WR);

  // mask is sticky, so reset leaves it alone; power-up value is zero
  initial hub_error_mask_r = `HLE_RST_MASK;
  always @(posedge core_clk) begin
    if (wr_mask) begin
      hub_error_mask_r <= hub_error_mask_nxt;
    end
  end

  // register images as software sees them, reserved bits tied low
  wire [7:0] hub_first_error_log;
  wire [7:0] hub_next_error_log;
  wire [7:0] hub_error_mask;
  reg [31:0] global_first_error_log;
  reg [31:0] global_next_error_log;
  assign hub_first_error_log = {1'b0, first_q};
  assign hub_next_error_log = {1'b0, next_q};
  assign hub_error_mask = {1'b0, hub_error_mask_r};

  always @* begin
    global_first_error_log = 32'h0000_0000;
    global_first_error_log[`HLE_GBIT_FATAL] = gf_fatal_q;
    global_first_error_log[`HLE_GBIT_NONFATAL] = gf_nonf_q;
  end

  always @* begin
    global_next_error_log = 32'h0000_0000;
    global_next_error_log[`HLE_GBIT_FATAL] = gn_fatal_q;
    global_next_error_log[`HLE_GBIT_NONFATAL] = gn_nonf_q;
  end

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (reg_addr)
      `HLE_OFF_FIRST: rd_nxt = {24'h00_0000, hub_first_error_log};
      `HLE_OFF_NEXT: rd_nxt = {24'h00_0000, hub_next_error_log};
      `HLE_OFF_MASK: rd_nxt = {24'h00_0000, hub_error_mask};
      `HLE_OFF_GFIRST: rd_nxt = global_first_error_log;
      `HLE_OFF_GNEXT: rd_nxt = global_next_error_log;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk) begin
    if (reset) begin
      reg_rdata_r <= 32'h0000_0000;
      fatal_logged_r <= 1'b0;
      nonfatal_logged_r <= 1'b0;
    end else begin
      reg_rdata_r <= reg_rd ? rd_nxt : 32'h0000_0000;
      fatal_logged_r <= fatal_ev;
      nonfatal_logged_r <= nonfatal_ev;
    end
  end
endmodule // hle_error_log

// [testbench/hle_hub_peer.sv]
// Purpose: hub side source of error events
// Assumes: one event per requested cycle
// Notes: a held request repeats the event each cycle
`timescale 1ns/1ns
module hle_hub_peer (
  // clock
  input wire core_clk,
  // request and events
  input wire [6:0] fire,
  output reg [6:0] err
);
  initial err = 7'h00;
  always @(posedge core_clk) begin
    err <= fire;
  end
endmodule // hle_hub_peer

// [testbench/hle_log_properties.sv]
// Purpose: port checks for the error log
// Assumes: read data one cycle after the strobe
// Notes: mask state is hidden, so checks tie outputs to inputs
`timescale 1ns/1ns
module hle_log_chk (
  // clock and reset
  input logic core_clk,
  input logic reset,
  // register port
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic [31:0] reg_rdata_r,
  // error sources
  input logic err_target_abort,
  input logic err_ecfg_legacy,
  input logic err_data_parity,
  input logic err_addr_range,
  input logic err_internal_parity,
  input logic err_illegal_access,
  input logic err_addr_cmd_parity,
  // summaries
  input logic fatal_logged_r,
  input logic nonfatal_logged_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire fat = err_ecfg_legacy | err_addr_range | err_illegal_access | err_addr_cmd_parity;
  wire nf = err_target_abort | err_data_parity | err_internal_parity;
  property p_fat; fatal_logged_r |-> $past(fat); endproperty
  a_fat: assert property (p_fat) else $error("fatal without cause");
  property p_nf; nonfatal_logged_r |-> $past(nf); endproperty
  a_nf: assert property (p_nf) else $error("nonfatal without cause");
  property p_ill; err_illegal_access |=> fatal_logged_r; endproperty
  a_ill: assert property (p_ill) else $error("illegal access lost");
  property p_idle; !$past(reg_rd) |-> reg_rdata_r == 0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read");
  property p_res; reg_rd && reg_addr[7:4] == 4'h5 |=> reg_rdata_r[31:7] == 0; endproperty
  a_res: assert property (p_res) else $error("reserved bits set");
  property p_m1; reg_rd && reg_addr == 8'h54 ##1 1 |-> !reg_rdata_r[1]; endproperty
  a_m1: assert property (p_m1) else $error("mask bit one set");
  property p_g40; reg_rd && reg_addr == 8'h40 |=> (reg_rdata_r & ~32'h02000800) == 0;
  endproperty
  a_g40: assert property (p_g40) else $error("global first stray bit");
  property p_g44; reg_rd && reg_addr == 8'h44 |=> (reg_rdata_r & ~32'h02000800) == 0;
  endproperty
  a_g44: assert property (p_g44) else $error("global next stray bit");
  cover property (fatal_logged_r);
  cover property (nonfatal_logged_r);
  cover property ($past(reg_rd) && reg_rdata_r != 0);
endmodule // hle_log_chk

// [testbench/tb.sv]
// Purpose: self-checking bench for the error log
// Assumes: reads are scored one cycle after the strobe
// Notes: mask is left random at the end
`timescale 1ns/1ns
module tb;
  logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, s = 83;
  logic [6:0] fire = 0;
  wire [6:0] err;
  wire [31:0] reg_rdata_r;
  wire fatal_logged_r, nonfatal_logged_r;
  wire [1:0] summ = {fatal_logged_r, nonfatal_logged_r};
  logic [31:0] expq[$];
  logic [1:0] sumq[$];
  int fail_count = 0, comparisons = 0;
  always #10 core_clk = ~core_clk;
  hle_hub_peer hle_hub_peer_inst (.core_clk(core_clk), .fire(fire), .err(err));
  hle_error_log hle_error_log_inst (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .err_target_abort(err[6]), .err_ecfg_legacy(err[5]), .err_data_parity(err[4]),
    .err_addr_range(err[3]), .err_internal_parity(err[2]), .err_illegal_access(err[1]),
    .err_addr_cmd_parity(err[0]), .fatal_logged_r(fatal_logged_r),
    .nonfatal_logged_r(nonfatal_logged_r));
  function automatic [31:0] xs(input [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // every signal is set once per edge, so back-to-back strobes stay clean
  task op(input logic w, r, input [7:0] a, input [31:0] d, input [6:0] e);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    fire <= e;
    @(posedge core_clk);
  endtask
  task rd(input [7:0] a, input [31:0] x);
    expq.push_back(x);
    op(0, 1, a, 0, 0);
  endtask
  task chk(input string n, input [31:0] seen, x);
    comparisons++;
    if (seen !== x) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, x, seen);
    end
  endtask
  task stop_test;
    if (expq.size() != 0 || sumq.size() != 0) fail_count++;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk) rd_d <= reg_rd;
  always @(negedge core_clk) if (rd_d) chk("read data", reg_rdata_r, expq.pop_front());
  // a summary pulse with no note pending is scored against zero
  always @(negedge core_clk) if (summ != 2'b00)
    chk("summary", summ, sumq.size() ? sumq.pop_front() : 2'b00);
  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 0;
    rd(8'h50, 0);
    rd(8'h54, 0);
    op(1, 0, 8'h54, 32'hff, 0);
    rd(8'h54, 32'h7d);
    sumq.push_back(2'b10);
    op(0, 0, 0, 0, 7'h7f);
    repeat (2) op(0, 0, 0, 0, 0);
    rd(8'h50, 32'h02);
    rd(8'h52, 0);
    op(1, 0, 8'h54, 0, 0);
    sumq.push_back(2'b01);
    op(0, 0, 0, 0, 7'h10);
    repeat (2) op(0, 0, 0, 0, 0);
    rd(8'h52, 32'h10);
    rd(8'h50, 32'h02);
    rd(8'h40, 32'h02000000);
    rd(8'h44, 32'h00000800);
    op(1, 0, 8'h40, 32'h02000800, 0);
    op(1, 0, 8'h44, 32'h02000800, 0);
    rd(8'h40, 0);
    rd(8'h44, 0);
    for (int i = 0; i < 7; i++) begin
      op(1, 0, 8'h50, 32'hff, 0);
      op(1, 0, 8'h52, 32'hff, 0);
      sumq.push_back(i inside {0, 1, 3, 5} ? 2'b10 : 2'b01);
      op(0, 0, 0, 0, 7'(1 << i));
      repeat (2) op(0, 0, 0, 0, 0);
      rd(8'h50, 32'h1 << i);
    end
    op(1, 0, 8'h50, 32'hff, 0);
    sumq.push_back(2'b10);
    op(0, 0, 0, 0, 7'h09);
    repeat (2) op(0, 0, 0, 0, 0);
    rd(8'h50, 32'h09);
    reset <= 1;
    repeat (4) op(0, 0, 0, 0, 0);
    reset <= 0;
    rd(8'h50, 32'h09);
    op(1, 0, 8'h50, 32'h88, 0);
    rd(8'h50, 32'h01);
    repeat (4) begin
      s = xs(s);
      op(1, 0, 8'h54, s, 0);
      rd(8'h54, s & 32'h7d);
      rd(8'h60 | {3'h0, s[12:8]}, 0);
    end
    repeat (2) op(0, 0, 0, 0, 0);
    stop_test;
  end
endmodule // tb
bind hle_error_log hle_log_chk hle_log_chk_inst (.core_clk(core_clk), .reset(reset),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata_r(reg_rdata_r), .err_target_abort(err_target_abort),
  .err_ecfg_legacy(err_ecfg_legacy), .err_data_parity(err_data_parity),
  .err_addr_range(err_addr_range), .err_internal_parity(err_internal_parity),
  .err_illegal_access(err_illegal_access), .err_addr_cmd_parity(err_addr_cmd_parity),
  .fatal_logged_r(fatal_logged_r), .nonfatal_logged_r(nonfatal_logged_r));
